// ==== tb/bxs_exec_checker.sv ====
// Timing and result assertions for the execute slice
`timescale 1ns/1ns
`default_nettype none
module bxs_exec_checker (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic [7:0] file_rd_data,
    input wire logic file_rd_en,
    input wire logic file_wr_en,
    input wire logic [7:0] acc_q,
    input wire logic flag_neg_q,
    input wire logic flag_zero_q,
    input wire logic [7:0] product_high_byte,
    input wire logic [7:0] product_low_byte,
    input wire logic [11:0] indirect_pointer2,
    input wire logic [1:0] phase_q,
    input wire logic cycle_done,
    input wire logic executing_nop_q
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    wire logic [7:0] lit = instr_word[7:0];
    // Latched word that is not thrown away by a skip
    sequence s_lat(logic [15:0] m, logic [15:0] v);
        phase_q == 2'h0 && instr_valid && (instr_word & m) == v ##1 !executing_nop_q;
    endsequence
    chk_phase_wrap: assert property (phase_q == 2'h3 |=> phase_q == 2'h0)
        else $error("phase did not wrap");
    chk_read_phase: assert property (file_rd_en |-> phase_q == 2'h1)
        else $error("read strobe off phase");
    chk_done_phase: assert property (cycle_done == (phase_q == 2'h3))
        else $error("done off phase");
    chk_write_pulse: assert property (file_wr_en |-> phase_q == 2'h0 ##1 !file_wr_en)
        else $error("file write not one clock");
    chk_hold_state: assert property (phase_q != 2'h0 |-> $stable({acc_q, flag_neg_q,
        flag_zero_q, product_high_byte, product_low_byte})) else $error("state moved mid cycle");
    chk_or_result: assert property (s_lat(16'hff00, 16'h0900) |-> ##3
        acc_q == ($past(acc_q, 4) | $past(lit, 4)) && flag_neg_q == acc_q[7]
        && flag_zero_q == (acc_q == 8'h00)) else $error("or result wrong");
    chk_mul_product: assert property (s_lat(16'hff00, 16'h0d00) |-> ##3
        {product_high_byte, product_low_byte} == $past(acc_q, 4) * $past(lit, 4)
        && acc_q == $past(acc_q, 4)) else $error("product wrong");
    chk_ptr_high: assert property (s_lat(16'hfff0, 16'hee20) |-> ##3
        {4'h0, indirect_pointer2[11:8]} == ($past(lit, 4) & 8'h0f)) else $error("pointer high");
    chk_dec_flags: assert property (s_lat(16'hfc00, 16'h4c00) |-> ##3
        flag_neg_q == $past(flag_neg_q, 4) && flag_zero_q == $past(flag_zero_q, 4))
        else $error("decrement moved flags");
    chk_skip_nop: assert property (s_lat(16'hfc00, 16'h4c00) ##1 file_rd_data != 8'h01
        |-> ##4 executing_nop_q) else $error("no skip cycle");
endmodule // bxs_exec_checker
bind bxs_exec_slice bxs_exec_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .instr_word(instr_word), .instr_valid(instr_valid), .file_rd_data(file_rd_data),
    .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .acc_q(acc_q), .flag_neg_q(flag_neg_q),
    .flag_zero_q(flag_zero_q), .product_high_byte(product_high_byte),
    .product_low_byte(product_low_byte), .indirect_pointer2(indirect_pointer2),
    .phase_q(phase_q), .cycle_done(cycle_done), .executing_nop_q(executing_nop_q));
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the execute slice
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic instr_valid = 1'b1;
    logic [7:0] file_rd_data = 8'h00;
    logic [3:0] bank_pointer = 4'h0;
    wire [11:0] file_addr, ip0, ip1, ip2;
    wire [7:0] file_wr_data, acc_q, ph, pl;
    wire [1:0] phase_q;
    wire file_rd_en, file_wr_en, flag_neg_q, flag_zero_q, cycle_done, executing_nop_q, illegal_q;
    int error_cnt = 0;
    int n_checks = 0;
    logic nop_seen;
    bxs_exec_slice dut (.ref_clk(ref_clk), .rst_b(rst_b), .instr_word(instr_word),
        .instr_valid(instr_valid), .file_rd_data(file_rd_data), .bank_pointer(bank_pointer),
        .file_addr(file_addr), .file_rd_en(file_rd_en), .file_wr_en(file_wr_en),
        .file_wr_data(file_wr_data), .acc_q(acc_q), .flag_neg_q(flag_neg_q),
        .flag_zero_q(flag_zero_q), .product_high_byte(ph), .product_low_byte(pl),
        .indirect_pointer0(ip0), .indirect_pointer1(ip1), .indirect_pointer2(ip2),
        .phase_q(phase_q), .cycle_done(cycle_done), .executing_nop_q(executing_nop_q),
        .illegal_q(illegal_q));
    always #5 ref_clk = ~ref_clk;
    function logic [15:0] af();
        return {acc_q, 6'h00, flag_neg_q, flag_zero_q};
    endfunction
    function logic [15:0] wf();
        return {file_wr_data, 7'h00, file_wr_en};
    endfunction
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One instruction cycle; an address of all ones skips the operand address check
    task op(input logic [15:0] w, input logic [7:0] rd, input logic [15:0] ea);
        instr_word <= w;
        file_rd_data <= rd;
        @(posedge ref_clk);
        #1;
        nop_seen = executing_nop_q;
        if (ea !== 16'hffff) chk({4'h0, file_addr}, ea);
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task end_of_test;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #5000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        op(16'h0900, 8'h00, 16'hffff);
        chk(af(), 16'h0001);
        op(16'h0980, 8'h00, 16'hffff);
        chk(af(), 16'h8002);
        op(16'h5034, 8'hc4, 16'h0034);
        chk(af(), 16'hc402);
        op(16'h0de2, 8'h00, 16'hffff);
        chk({ph, pl}, 16'had08);
        chk(af(), 16'hc402);
        bank_pointer <= 4'h5;
        op(16'h0334, 8'hb5, 16'h0534);
        chk({ph, pl}, 16'h8a94);
        chk(af() | {15'h0000, file_wr_en}, 16'hc402);
        op(16'h1290, 8'h13, 16'h0f90);
        chk(wf(), 16'hd701);
        op(16'h5290, 8'h00, 16'h0f90);
        chk(wf() ^ af(), 16'hc400);
        op(16'h4c10, 8'h01, 16'h0010);
        chk(af(), 16'h0001);
        op(16'h0901, 8'h00, 16'hffff);
        chk(af(), 16'h0100);
        op(16'h4e10, 8'h05, 16'h0010);
        chk(wf(), 16'h0401);
        op(16'h09f0, 8'h00, 16'hffff);
        chk({acc_q, 7'h00, nop_seen}, 16'h0101);
        chk(af(), 16'h0100);
        op(16'h4c10, 8'h03, 16'h0010);
        op(16'hee1a, 8'h00, 16'hffff);
        op(16'hf0bc, 8'h00, 16'hffff);
        chk({ip1, 3'h0, nop_seen}, 16'h0001);
        chk(af(), 16'h0200);
        op(16'hee2a, 8'h00, 16'hffff);
        chk({4'h0, ip2}, 16'h0a00);
        op(16'hf0bc, 8'h00, 16'hffff);
        chk({4'h0, ip2}, 16'h0abc);
        op(16'hee03, 8'h00, 16'hffff);
        op(16'hf045, 8'h00, 16'hffff);
        chk({4'h0, ip0}, 16'h0345);
        chk({15'h0000, illegal_q}, 16'h0000);
        chk(af(), 16'h0200);
        end_of_test;
    end
endmodule // tb
`default_nettype wire

// ==== verilog/bxs_bank_addr.v ====
// Operand address former: access bank or bank pointer
`timescale 1ns/1ns
`default_nettype none
`include "bxs_defs.vh"
module bxs_bank_addr (
    input wire [15:0] word,
    input wire [3:0] bank_pointer,
    output wire [11:0] addr
);
    wire access_sel;
    assign access_sel = word[`BXS_BIT_ACCESS];
    // bank choice
    // Access bank splits: low half in bank 0, upper half in the top bank
    assign addr = access_sel ? {bank_pointer, word[7:0]} :
        (word[7:0] < `BXS_ACCESS_SPLIT) ? {4'h0, word[7:0]} :
        {`BXS_ACCESS_HI_BANK, word[7:0]};
endmodule // bxs_bank_addr
`default_nettype wire

// ==== verilog/bxs_defs.vh ====
// Constants for the byte-op execute slice
`ifndef BXS_DEFS_VH
`define BXS_DEFS_VH
`define BXS_OP6_OR_FILE 6'h04
`define BXS_OP6_DEC_SKIP_NZ 6'h13
`define BXS_OP6_COPY_FILE 6'h14
`define BXS_OP7_MUL_FILE 7'h01
`define BXS_OP8_OR_IMM 8'h09
`define BXS_OP8_MUL_IMM 8'h0d
`define BXS_OP10_PTR_FIRST 10'h3b8
`define BXS_OP8_PTR_SECOND 8'hf0
`define BXS_OP4_TWO_WORD_C 4'hc
`define BXS_OP4_TWO_WORD_F 4'hf
`define BXS_BIT_DEST 9
`define BXS_BIT_ACCESS 8
`define BXS_ACCESS_SPLIT 8'h80
`define BXS_ACCESS_HI_BANK 4'hf
`define BXS_PH_DECODE 2'h0
`define BXS_PH_READ 2'h1
`define BXS_PH_PROCESS 2'h2
`define BXS_PH_WRITE 2'h3
`endif

// ==== verilog/bxs_exec_slice.v ====
// Execute slice for seven byte-op instructions of an 8-bit core
`timescale 1ns/1ns
`default_nettype none
`include "bxs_defs.vh"
module bxs_exec_slice #(
    parameter DATA_W = 8,
    parameter ADDR_W = 12
) (
    input wire ref_clk,
    input wire rst_b,
    input wire [15:0] instr_word,
    input wire instr_valid,
    input wire [DATA_W-1:0] file_rd_data,
    input wire [3:0] bank_pointer,
    output wire [ADDR_W-1:0] file_addr,
    output wire file_rd_en,
    output reg file_wr_en,
    output reg [DATA_W-1:0] file_wr_data,
    output reg [DATA_W-1:0] acc_q,
    output reg flag_neg_q,
    output reg flag_zero_q,
    output reg [DATA_W-1:0] product_high_byte,
    output reg [DATA_W-1:0] product_low_byte,
    output reg [ADDR_W-1:0] indirect_pointer0,
    output reg [ADDR_W-1:0] indirect_pointer1,
    output reg [ADDR_W-1:0] indirect_pointer2,
    output reg [1:0] phase_q,
    output wire cycle_done,
    output reg executing_nop_q,
    output reg illegal_q
);
    localparam ST_FIRST = 2'd0;
    localparam ST_SKIP = 2'd1;
    localparam ST_PTR_LOW = 2'd2;
    localparam ST_SKIP_TAIL = 2'd3;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [15:0] ir_q;
    reg [DATA_W-1:0] opnd_q;
    reg [DATA_W-1:0] res_q;
    reg [2*DATA_W-1:0] prod_q;
    reg [1:0] ptr_sel_q;
    wire [ADDR_W-1:0] banked_addr;

    ////////////////////////////////////////////////////////////////////
    // Opcode decode of the latched word
    wire is_or_file;
    wire is_dec_skip;
    wire is_copy;
    wire is_mul_file;
    wire is_or_imm;
    wire is_mul_imm;
    wire is_ptr_first;
    wire is_file_op;
    wire dest_file;
    wire is_two_word;
    assign is_or_file = (ir_q[15:10] == `BXS_OP6_OR_FILE);
    assign is_dec_skip = (ir_q[15:10] == `BXS_OP6_DEC_SKIP_NZ);
    assign is_copy = (ir_q[15:10] == `BXS_OP6_COPY_FILE);
    assign is_mul_file = (ir_q[15:9] == `BXS_OP7_MUL_FILE);
    assign is_or_imm = (ir_q[15:8] == `BXS_OP8_OR_IMM);
    assign is_mul_imm = (ir_q[15:8] == `BXS_OP8_MUL_IMM);
    assign is_ptr_first = (ir_q[15:6] == `BXS_OP10_PTR_FIRST);
    assign is_file_op = is_or_file | is_dec_skip | is_copy | is_mul_file;
    assign dest_file = ir_q[`BXS_BIT_DEST];
    // Two-word first words in this core begin with 1100 or 1110 1110
    assign is_two_word = (ir_q[15:12] == `BXS_OP4_TWO_WORD_C) ||
        (ir_q[15:8] == 8'hee);

    ////////////////////////////////////////////////////////////////////
    // Operand addressing
    bxs_bank_addr u_bank (
        .word(ir_q),
        .bank_pointer(bank_pointer),
        .addr(banked_addr)
    );
    assign file_addr = banked_addr;
    assign file_rd_en = (state_q == ST_FIRST) && is_file_op && (phase_q == `BXS_PH_READ);
    assign cycle_done = (phase_q == `BXS_PH_WRITE);

    ////////////////////////////////////////////////////////////////////
    // Next-state for multi-cycle sequences
    always @* begin
        state_d = ST_FIRST;
        case (state_q)
            ST_FIRST: begin
                if (is_dec_skip && (res_q != {DATA_W{1'b0}}))
                    state_d = ST_SKIP;
                else if (is_ptr_first)
                    state_d = ST_PTR_LOW;
                else
                    state_d = ST_FIRST;
            end
            ST_SKIP: begin
                if (is_two_word)
                    state_d = ST_SKIP_TAIL;
                else
                    state_d = ST_FIRST;
            end
            ST_PTR_LOW: state_d = ST_FIRST;
            ST_SKIP_TAIL: state_d = ST_FIRST;
            default: state_d = ST_FIRST;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Quarter-phase sequencer
    // A live cycle runs its latched word; skip and second-word cycles do not
    wire live_cycle;
    wire write_quarter;
    assign live_cycle = (state_q == ST_FIRST);
    assign write_quarter = (phase_q == `BXS_PH_WRITE);

    // Quarters wrap freely; an instruction cycle is always four clocks
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= `BXS_PH_DECODE;
            state_q <= ST_FIRST;
        end else begin
            phase_q <= phase_q + 2'd1;
            // Multi-cycle state moves only at the cycle boundary
            if (write_quarter) begin
                state_q <= state_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Decode quarter
    // decode quarter
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ir_q <= 16'h0000;
            executing_nop_q <= 1'b0;
        end else if (phase_q == `BXS_PH_DECODE) begin
            // Word is latched every cycle; skip cycles still consume it
            // An invalid fetch loads an all-zero word, which decodes to nothing here
            ir_q <= instr_valid ? instr_word : 16'h0000;
            // both words of a skipped pair
            executing_nop_q <= (state_q == ST_SKIP) || (state_q == ST_SKIP_TAIL);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read quarter
    // operand read quarter
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            opnd_q <= {DATA_W{1'b0}};
            illegal_q <= 1'b0;
        end else if (phase_q == `BXS_PH_READ) begin
            // Immediates come from the low byte of the latched word
            if (is_or_imm || is_mul_imm) begin
                opnd_q <= ir_q[DATA_W-1:0];
            end else begin
                opnd_q <= file_rd_data;
            end
            // Second pointer word must carry its fixed prefix; the low byte is
            // still written, so a bad program leaves a flag rather than a hang
            if (state_q == ST_PTR_LOW) begin
                illegal_q <= (ir_q[15:8] != `BXS_OP8_PTR_SECOND);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Process quarter
    // process quarter
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            res_q <= {DATA_W{1'b0}};
            prod_q <= {(2*DATA_W){1'b0}};
        end else if ((phase_q == `BXS_PH_PROCESS) && live_cycle) begin
            // decrement
            // Decrement wraps from zero to all ones, which counts as nonzero
            if (is_dec_skip) begin
                res_q <= opnd_q - {{(DATA_W-1){1'b0}}, 1'b1};
            end else if (is_or_file || is_or_imm) begin
                res_q <= acc_q | opnd_q;
            end else begin
                res_q <= opnd_q;
            end
            // unsigned product
            // Formed every live cycle; only a multiply hands it on
            prod_q <= acc_q * opnd_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write quarter: one intent per destination, so no register has two writers
    wire dest_op;
    wire wr_dest_file;
    wire wr_dest_acc;
    wire wr_flags;
    wire wr_product;
    wire wr_ptr_high;
    wire wr_ptr_low;
    wire [1:0] ptr_index;
    wire [3:0] ptr_high_nibble;
    wire [7:0] ptr_low_byte;

    // Skip cycles never reach these; live_cycle gates all but wr_ptr_low, which fires in the second-word cycle
    assign dest_op = is_dec_skip || is_or_file || is_copy;
    assign wr_dest_file = write_quarter && live_cycle && dest_op && dest_file;
    assign wr_dest_acc = write_quarter && live_cycle && ((dest_op && !dest_file) || is_or_imm);
    assign wr_flags = write_quarter && live_cycle && (is_or_file || is_or_imm || is_copy);
    assign wr_product = write_quarter && live_cycle && (is_mul_imm || is_mul_file);
    assign wr_ptr_high = write_quarter && live_cycle && is_ptr_first;
    // low byte in the second cycle
    assign wr_ptr_low = write_quarter && (state_q == ST_PTR_LOW);
    // Pointer fields of the two words
    assign ptr_index = ir_q[5:4];
    assign ptr_high_nibble = ir_q[3:0];
    assign ptr_low_byte = ir_q[7:0];

    ////////////////////////////////////////////////////////////////////
    // File write port
    // The strobe is one clock long and meets the file in the next decode quarter
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            file_wr_en <= 1'b0;
            file_wr_data <= {DATA_W{1'b0}};
        end else begin
            file_wr_en <= wr_dest_file;
            if (wr_dest_file) begin
                file_wr_data <= res_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Accumulator and status flags
    // A file destination leaves the accumulator alone, decrement included
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= {DATA_W{1'b0}};
            flag_neg_q <= 1'b0;
            flag_zero_q <= 1'b0;
        end else begin
            if (wr_dest_acc) begin
                acc_q <= res_q;
            end
            if (wr_flags) begin
                flag_neg_q <= res_q[DATA_W-1];
                flag_zero_q <= (res_q == {DATA_W{1'b0}});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Product pair; both bytes always change together
    // No flag or accumulator path leaves from here
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            product_high_byte <= {DATA_W{1'b0}};
            product_low_byte <= {DATA_W{1'b0}};
        end else if (wr_product) begin
            product_high_byte <= prod_q[2*DATA_W-1:DATA_W];
            product_low_byte <= prod_q[DATA_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Indirect pointers; index 3 has no register in this slice and is ignored
    localparam PTR_IDX0 = 2'd0;
    localparam PTR_IDX1 = 2'd1;
    localparam PTR_IDX2 = 2'd2;
    wire [2:0] ptr_high_hit;
    wire [2:0] ptr_low_hit;
    assign ptr_high_hit[0] = wr_ptr_high && (ptr_index == PTR_IDX0);
    assign ptr_high_hit[1] = wr_ptr_high && (ptr_index == PTR_IDX1);
    assign ptr_high_hit[2] = wr_ptr_high && (ptr_index == PTR_IDX2);
    // The second word has no room for the index, so the first word's is kept
    assign ptr_low_hit[0] = wr_ptr_low && (ptr_sel_q == PTR_IDX0);
    assign ptr_low_hit[1] = wr_ptr_low && (ptr_sel_q == PTR_IDX1);
    assign ptr_low_hit[2] = wr_ptr_low && (ptr_sel_q == PTR_IDX2);

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_sel_q <= 2'h0;
        end else if (wr_ptr_high) begin
            ptr_sel_q <= ptr_index;
        end
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            indirect_pointer0 <= {ADDR_W{1'b0}};
        end else if (ptr_high_hit[0]) begin
            indirect_pointer0[11:8] <= ptr_high_nibble;
        end else if (ptr_low_hit[0]) begin
            indirect_pointer0[7:0] <= ptr_low_byte;
        end
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            indirect_pointer1 <= {ADDR_W{1'b0}};
        end else if (ptr_high_hit[1]) begin
            indirect_pointer1[11:8] <= ptr_high_nibble;
        end else if (ptr_low_hit[1]) begin
            indirect_pointer1[7:0] <= ptr_low_byte;
        end
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            indirect_pointer2 <= {ADDR_W{1'b0}};
        end else if (ptr_high_hit[2]) begin
            indirect_pointer2[11:8] <= ptr_high_nibble;
        end else if (ptr_low_hit[2]) begin
            indirect_pointer2[7:0] <= ptr_low_byte;
        end
    end
endmodule // bxs_exec_slice
`default_nettype wire
